/* File: verilog/casr_map.svh */
`ifndef CASR_MAP_SVH
`define CASR_MAP_SVH

// Register indices; byte address is four times the index
`define CASR_IDX_STACK_TOP 8'h81
`define CASR_IDX_FLAG_WORD 8'hd0
`define CASR_IDX_PRIMARY 8'he0
`define CASR_IDX_SECOND 8'hf0

// Reset values
`define CASR_RST_STACK_TOP 8'h07
`define CASR_RST_ZERO 8'h00

// Flag word field positions
`define CASR_BIT_CARRY 7
`define CASR_BIT_HALF_CARRY 6
`define CASR_BIT_USER_ZERO 5
`define CASR_BIT_BANK_HI 4
`define CASR_BIT_BANK_LO 3
`define CASR_BIT_SIGNED_WRAP 2
`define CASR_BIT_USER_ONE 1
`define CASR_BIT_PARITY 0

// Working-register bank base is select shifted left by this
`define CASR_BANK_SHIFT 3

`endif

/* File: verilog/casr_pkg.sv */
package casr_pkg;

    typedef enum logic [2:0] {
        CASR_OP_LOAD,
        CASR_OP_ADD,
        CASR_OP_ADDC,
        CASR_OP_SUBB,
        CASR_OP_MUL,
        CASR_OP_DIV
    } casr_alu_op_e;

    typedef struct packed {
        logic cy;
        logic ac;
        logic ov;
    } casr_flags_s;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] b;
        casr_flags_s flags;
        logic upd_b;
        logic upd_cy;
        logic upd_ac;
        logic upd_ov;
    } casr_alu_res_s;

endpackage

/* File: verilog/casr_alu.sv */
`timescale 1ns/10ps
module casr_alu (
    // Operation
    input wire casr_pkg::casr_alu_op_e op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [7:0] src,
    input wire logic cy_in,
    // Result
    output casr_pkg::casr_alu_res_s res
);
    logic cin;
    logic [8:0] sum9;
    logic [4:0] sum_lo;
    logic [8:0] dif9;
    logic [4:0] dif_lo;
    logic [15:0] prod;
    logic div_zero;

    assign cin = (op == casr_pkg::CASR_OP_ADDC) ? cy_in : 1'b0;
    assign sum9 = {1'b0, a} + {1'b0, src} + {8'h00, cin};
    assign sum_lo = {1'b0, a[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
    assign dif9 = {1'b0, a} - {1'b0, src} - {8'h00, cy_in};
    assign dif_lo = {1'b0, a[3:0]} - {1'b0, src[3:0]} - {4'h0, cy_in};
    assign prod = {8'h00, a} * {8'h00, b};
    assign div_zero = (b == 8'h00);

    always_comb begin
        res = '0;
        res.acc = a;
        res.b = b;
        case (op)
            casr_pkg::CASR_OP_LOAD: begin
                res.acc = src;
            end
            casr_pkg::CASR_OP_ADD, casr_pkg::CASR_OP_ADDC: begin
                res.acc = sum9[7:0];
                res.flags.cy = sum9[8];
                res.flags.ac = sum_lo[4];
                res.flags.ov = (a[7] == src[7]) && (sum9[7] != a[7]);
                res.upd_cy = 1'b1;
                res.upd_ac = 1'b1;
                res.upd_ov = 1'b1;
            end
            casr_pkg::CASR_OP_SUBB: begin
                res.acc = dif9[7:0];
                res.flags.cy = dif9[8];
                res.flags.ac = dif_lo[4];
                res.flags.ov = (a[7] != src[7]) && (dif9[7] != a[7]);
                res.upd_cy = 1'b1;
                res.upd_ac = 1'b1;
                res.upd_ov = 1'b1;
            end
            casr_pkg::CASR_OP_MUL: begin
                res.acc = prod[7:0];
                res.b = prod[15:8];
                res.flags.ov = (prod[15:8] != 8'h00);
                res.upd_b = 1'b1;
                res.upd_cy = 1'b1;
                res.upd_ov = 1'b1;
            end
            casr_pkg::CASR_OP_DIV: begin
                // Divide by zero leaves both operands untouched
                if (!div_zero) begin
                    res.acc = a / b;
                    res.b = a % b;
                end
                res.flags.ov = div_zero;
                res.upd_b = 1'b1;
                res.upd_cy = 1'b1;
                res.upd_ov = 1'b1;
            end
            default: begin
                res.acc = a;
            end
        endcase
    end
endmodule

/* File: verilog/casr_regs.sv */
// Overview of operation
// - Eight-bit read/write stack top pointer
// - Push increments pointer, byte stored there
// - Pointer resets to 07, others to zero
// - Operand and flag registers bit-addressable, all pages
// - Primary operand is the arithmetic accumulator
// - Second operand extends multiply and divide
// - Carry flag bit 7 on carry/borrow
// - Half-carry bit 6 on nibble carry/borrow
// - Half-carry cleared otherwise by add/subtract, kept by mul and div
// - Bank select bits 4:3 pick register bank
// - Wrap flag on signed overflow, mul, div0
// - Wrap flag cleared when no overflow
// - User flags written only by software
`timescale 1ns/10ps
`include "casr_map.svh"
module casr_regs (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [9:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Core arithmetic request
    input wire logic ALU_VALID,
    input wire casr_pkg::casr_alu_op_e ALU_OP,
    input wire logic [7:0] ALU_SRC,
    // Core bit access
    input wire logic BIT_WE,
    input wire logic [7:0] BIT_ADDR,
    input wire logic BIT_VAL,
    // Core stack requests
    input wire logic PUSH_REQ,
    input wire logic [7:0] PUSH_DATA,
    input wire logic POP_REQ,
    output logic STACK_WE,
    output logic [7:0] STACK_ADDR,
    output logic [7:0] STACK_DATA,
    // Architectural state
    output logic [7:0] STACK_TOP,
    output logic [7:0] PRIMARY_OPERAND,
    output logic [7:0] SECOND_OPERAND,
    output logic [7:0] CORE_FLAG_WORD,
    output logic [7:0] BANK_BASE
);
    // Register file; parity is never stored, only derived
    logic [7:0] sp_q, sp_d;
    logic [7:0] acc_q, acc_d;
    logic [7:0] b_q, b_d;
    logic [7:1] psw_q, psw_d;
    logic [7:0] psw_bit;
    logic ack_q;
    logic [31:0] dat_q, dat_d;
    logic stk_we_q;
    logic [7:0] stk_addr_q, stk_data_q;

    casr_pkg::casr_alu_res_s alu_res;

    function automatic logic bit_hit(input logic [7:0] addr,
                                     input logic [7:0] base);
        bit_hit = (addr[7:3] == base[7:3]);
    endfunction

    function automatic logic [7:0] bit_put(input logic [7:0] v,
                                           input logic [2:0] pos,
                                           input logic val);
        logic [7:0] r;
        r = v;
        r[pos] = val;
        bit_put = r;
    endfunction

    // Bus decode; no page input, so every page sees the same map
    wire wb_req = WB_CYC_I & WB_STB_I;
    wire [7:0] wb_idx = WB_ADR_I[9:2];
    wire wb_wr = wb_req & WB_WE_I & ack_q & WB_SEL_I[0];
    wire [7:0] wb_byte = WB_DAT_I[7:0];
    wire wr_sp = wb_wr & (wb_idx == `CASR_IDX_STACK_TOP);
    wire wr_acc = wb_wr & (wb_idx == `CASR_IDX_PRIMARY);
    wire wr_b = wb_wr & (wb_idx == `CASR_IDX_SECOND);
    wire wr_psw = wb_wr & (wb_idx == `CASR_IDX_FLAG_WORD);

    // Bit access decode
    wire bit_acc = BIT_WE & bit_hit(BIT_ADDR, `CASR_IDX_PRIMARY);
    wire bit_b = BIT_WE & bit_hit(BIT_ADDR, `CASR_IDX_SECOND);
    wire bit_psw = BIT_WE & bit_hit(BIT_ADDR, `CASR_IDX_FLAG_WORD);

    wire parity = ^acc_q;
    wire [7:0] psw_full = {psw_q, parity};
    wire [7:0] psw_wr_val = bit_put(wb_byte, 3'h0, 1'b0);

    // Read mux, unmapped indices read zero
    wire [7:0] rd_byte =
        (wb_idx == `CASR_IDX_STACK_TOP) ? sp_q :
        (wb_idx == `CASR_IDX_PRIMARY) ? acc_q :
        (wb_idx == `CASR_IDX_SECOND) ? b_q :
        (wb_idx == `CASR_IDX_FLAG_WORD) ? psw_full : 8'h00;

    casr_alu u_alu (
        .op(ALU_OP),
        .a(acc_q),
        .b(b_q),
        .src(ALU_SRC),
        .cy_in(psw_q[`CASR_BIT_CARRY]),
        .res(alu_res)
    );

    // Order: bus write, then bit access, then core result, so a
    // hardware update in the same cycle wins over software
    always_comb begin
        acc_d = acc_q;
        b_d = b_q;
        psw_d = psw_q;
        psw_bit = 8'h00;
        if (wr_acc) begin
            acc_d = wb_byte;
        end
        if (wr_b) begin
            b_d = wb_byte;
        end
        if (wr_psw) begin
            psw_d = psw_wr_val[7:1];
        end
        if (bit_acc) begin
            acc_d = bit_put(acc_d, BIT_ADDR[2:0], BIT_VAL);
        end
        if (bit_b) begin
            b_d = bit_put(b_d, BIT_ADDR[2:0], BIT_VAL);
        end
        if (bit_psw && (BIT_ADDR[2:0] != 3'h0)) begin
            psw_bit = bit_put({psw_d, 1'b0}, BIT_ADDR[2:0], BIT_VAL);
            psw_d = psw_bit[7:1];
        end
        if (ALU_VALID) begin
            acc_d = alu_res.acc;
            if (alu_res.upd_b) begin
                b_d = alu_res.b;
            end
            if (alu_res.upd_cy) begin
                psw_d[`CASR_BIT_CARRY] = alu_res.flags.cy;
            end
            if (alu_res.upd_ac) begin
                psw_d[`CASR_BIT_HALF_CARRY] = alu_res.flags.ac;
            end
            if (alu_res.upd_ov) begin
                psw_d[`CASR_BIT_SIGNED_WRAP] = alu_res.flags.ov;
            end
        end
    end

    // Stack pointer next value; push beats pop and bus write
    always_comb begin
        sp_d = sp_q;
        if (wr_sp) begin
            sp_d = wb_byte;
        end
        if (PUSH_REQ) begin
            sp_d = sp_q + 8'h01;
        end else if (POP_REQ) begin
            sp_d = sp_q - 8'h01;
        end
    end

    assign dat_d = (wb_req & ~ack_q) ? {24'h000000, rd_byte} : dat_q;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sp_q <= `CASR_RST_STACK_TOP;
            acc_q <= `CASR_RST_ZERO;
            b_q <= `CASR_RST_ZERO;
            psw_q <= 7'h00;
        end else begin
            sp_q <= sp_d;
            acc_q <= acc_d;
            b_q <= b_d;
            psw_q <= psw_d;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= wb_req & ~ack_q;
            dat_q <= dat_d;
        end
    end

    // Stack write goes to the incremented location
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            stk_we_q <= 1'b0;
            stk_addr_q <= `CASR_RST_ZERO;
            stk_data_q <= `CASR_RST_ZERO;
        end else begin
            stk_we_q <= PUSH_REQ;
            if (PUSH_REQ) begin
                stk_addr_q <= sp_q + 8'h01;
                stk_data_q <= PUSH_DATA;
            end
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;
    assign STACK_WE = stk_we_q;
    assign STACK_ADDR = stk_addr_q;
    assign STACK_DATA = stk_data_q;
    assign STACK_TOP = sp_q;
    assign PRIMARY_OPERAND = acc_q;
    assign SECOND_OPERAND = b_q;
    assign CORE_FLAG_WORD = psw_full;
    // Bank base: select code 10 gives 0x10..0x17
    assign BANK_BASE = {3'h0, psw_q[`CASR_BIT_BANK_HI:`CASR_BIT_BANK_LO],
                        3'h0};
endmodule

/* File: testbench/casr_regs_sva.sv */
`timescale 1ns/10ps
module casr_sva (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // Bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic WB_ACK_O,
    // Core requests
    input wire logic ALU_VALID,
    input wire casr_pkg::casr_alu_op_e ALU_OP,
    input wire logic [7:0] ALU_SRC,
    input wire logic BIT_WE,
    input wire logic PUSH_REQ,
    input wire logic [7:0] PUSH_DATA,
    input wire logic POP_REQ,
    input wire logic STACK_WE,
    input wire logic [7:0] STACK_ADDR,
    input wire logic [7:0] STACK_DATA,
    // State
    input wire logic [7:0] STACK_TOP,
    input wire logic [7:0] PRIMARY_OPERAND,
    input wire logic [7:0] SECOND_OPERAND,
    input wire logic [7:0] CORE_FLAG_WORD,
    input wire logic [7:0] BANK_BASE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    wire logic bus_wr = WB_CYC_I && WB_STB_I && WB_WE_I;
    wire logic op_ok = ALU_VALID;
    AST_PARITY: assert property (CORE_FLAG_WORD[0] == ^PRIMARY_OPERAND)
        else $error("parity bit differs from operand parity");
    AST_PUSH_INC: assert property (PUSH_REQ |=>
        STACK_TOP == $past(STACK_TOP) + 8'h01) else $error("push no inc");
    AST_PUSH_OUT: assert property (PUSH_REQ |=> STACK_WE &&
        STACK_ADDR == STACK_TOP && STACK_DATA == $past(PUSH_DATA))
        else $error("push write wrong");
    AST_POP: assert property (POP_REQ && !PUSH_REQ && !WB_CYC_I |=>
        STACK_TOP == $past(STACK_TOP) - 8'h01) else $error("pop no dec");
    AST_ACK_LAT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
        |=> WB_ACK_O ##1 !WB_ACK_O) else $error("ack timing wrong");
    AST_BANK: assert property (BANK_BASE ==
        {3'h0, CORE_FLAG_WORD[4:3], 3'h0}) else $error("bank base wrong");
    AST_LOAD: assert property (op_ok && ALU_OP == casr_pkg::CASR_OP_LOAD
        |=> PRIMARY_OPERAND == $past(ALU_SRC)) else $error("load lost");
    AST_USER: assert property (!BIT_WE && !bus_wr |=>
        $stable({CORE_FLAG_WORD[5], CORE_FLAG_WORD[1]}))
        else $error("user flag moved by hardware");
    AST_DIV0: assert property (op_ok && ALU_OP == casr_pkg::CASR_OP_DIV &&
        SECOND_OPERAND == 8'h00 |=> CORE_FLAG_WORD[2] &&
        $stable(PRIMARY_OPERAND)) else $error("divide by zero wrong");
    AST_MUL: assert property (op_ok && ALU_OP == casr_pkg::CASR_OP_MUL |=>
        CORE_FLAG_WORD[2] == (({8'h00, $past(PRIMARY_OPERAND)} *
        {8'h00, $past(SECOND_OPERAND)}) > 16'h00ff)) else $error("mul wrap");
    AST_ADD_CY: assert property (op_ok && ALU_OP == casr_pkg::CASR_OP_ADD
        |=> CORE_FLAG_WORD[7] == (({1'b0, $past(PRIMARY_OPERAND)} +
        $past(ALU_SRC)) > 9'h0ff)) else $error("add carry wrong");
    COV_PUSH: cover property (PUSH_REQ ##1 STACK_WE);
    COV_DIV0: cover property (op_ok && ALU_OP == casr_pkg::CASR_OP_DIV &&
        SECOND_OPERAND == 8'h00);
    COV_WR: cover property (bus_wr && WB_ACK_O);
endmodule

bind casr_regs casr_sva casr_sva_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ACK_O(WB_ACK_O), .ALU_VALID(ALU_VALID), .ALU_OP(ALU_OP),
    .ALU_SRC(ALU_SRC), .BIT_WE(BIT_WE), .PUSH_REQ(PUSH_REQ),
    .PUSH_DATA(PUSH_DATA), .POP_REQ(POP_REQ), .STACK_WE(STACK_WE),
    .STACK_ADDR(STACK_ADDR), .STACK_DATA(STACK_DATA),
    .STACK_TOP(STACK_TOP), .PRIMARY_OPERAND(PRIMARY_OPERAND),
    .SECOND_OPERAND(SECOND_OPERAND), .CORE_FLAG_WORD(CORE_FLAG_WORD),
    .BANK_BASE(BANK_BASE));

/* File: testbench/tb.sv */
`timescale 1ns/10ps
module tb;
    logic clk, rstn, cyc, we, av, bwe, bv, push, pop, swe;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, rd;
    logic ack;
    casr_pkg::casr_alu_op_e op;
    logic [7:0] src, ba, pd, sa, sd, sp, pa, sb, fw, bb, r;
    int bad_count, comparisons;
    // Address, write byte, expected read back
    logic [25:0] rows [6] = '{{10'h204, 8'h5a, 8'h5a},
        {10'h3c0, 8'ha5, 8'ha5}, {10'h380, 8'h3c, 8'h3c},
        {10'h340, 8'hff, 8'hfe}, {10'h100, 8'h77, 8'h00},
        {10'h340, 8'h11, 8'h10}};
    // Operation, source, expected primary/second/flags
    logic [34:0] alu_rows [7] = '{{3'd0, 8'h88, 24'h88a510},
        {3'd1, 8'h88, 24'h10a5d5}, {3'd1, 8'h01, 24'h11a510},
        {3'd4, 8'h00, 24'hf50a14}, {3'd5, 8'h00, 24'h180510},
        {3'd3, 8'h19, 24'hff05d0}, {3'd2, 8'h00, 24'h0005d0}};
    casr_regs casr_regs_i (.CORE_CLK(clk), .RESETN(rstn), .WB_CYC_I(cyc),
        .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .ALU_VALID(av),
        .ALU_OP(op), .ALU_SRC(src), .BIT_WE(bwe), .BIT_ADDR(ba),
        .BIT_VAL(bv), .PUSH_REQ(push), .PUSH_DATA(pd), .POP_REQ(pop),
        .STACK_WE(swe), .STACK_ADDR(sa), .STACK_DATA(sd), .STACK_TOP(sp),
        .PRIMARY_OPERAND(pa), .SECOND_OPERAND(sb), .CORE_FLAG_WORD(fw),
        .BANK_BASE(bb));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Waits on ack only; the slave may stretch its answer
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= {24'h0, d};
        // Only the watchdog ends a wait that never sees ack
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rd[7:0];
        cyc <= 1'b0;
    endtask
    task automatic alu(input logic [2:0] o, input logic [7:0] s);
        @(posedge clk);
        av <= 1'b1;
        op <= casr_pkg::casr_alu_op_e'(o);
        src <= s;
        @(posedge clk);
        av <= 1'b0;
        @(negedge clk);
    endtask
    task automatic bit_set(input logic [7:0] a);
        @(posedge clk);
        bwe <= 1'b1;
        ba <= a;
        bv <= 1'b1;
        @(posedge clk);
        bwe <= 1'b0;
        @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    initial begin
        {rstn, cyc, we, av, bwe, bv, push, pop} = '0;
        {adr, wd, src, ba, pd} = '0;
        sel = 4'hf;
        op = casr_pkg::CASR_OP_LOAD;
        repeat (5) @(posedge clk);
        chk(sp, 8'h07);
        chk({pa, sb, fw, bb}, 32'h0);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            wb(1'b1, rows[i][25:16], rows[i][15:8]);
            wb(1'b0, rows[i][25:16], 8'h00);
            chk(r, rows[i][7:0]);
        end
        chk(bb, 8'h10);
        sel <= 4'he;
        wb(1'b1, 10'h3c0, 8'h99);
        sel <= 4'hf;
        wb(1'b0, 10'h3c0, 8'h00);
        chk(r, 8'ha5);
        @(posedge clk);
        push <= 1'b1;
        pd <= 8'hc3;
        @(posedge clk);
        push <= 1'b0;
        pop <= 1'b1;
        @(negedge clk);
        chk({swe, sa, sd, sp}, {1'b1, 24'h5bc35b});
        @(posedge clk);
        pop <= 1'b0;
        @(negedge clk);
        chk(sp, 8'h5a);
        foreach (alu_rows[i]) begin
            alu(alu_rows[i][34:32], alu_rows[i][31:24]);
            chk({pa, sb, fw}, alu_rows[i][23:0]);
        end
        wb(1'b1, 10'h3c0, 8'h00);
        alu(3'd5, 8'h00);
        chk({pa, sb, fw}, 24'h000054);
        bit_set(8'hd5);
        chk(fw, 8'h74);
        bit_set(8'he7);
        chk({pa, fw}, 16'h8075);
        bit_set(8'hf3);
        bit_set(8'hd0);
        chk({sb, fw}, 16'h0875);
        // Reset in mid-run must restore pointer, operands and flag word
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        chk(sp, 8'h07);
        chk({pa, sb, fw, bb}, 32'h0);
        rstn <= 1'b1;
        wb(1'b0, 10'h204, 8'h00);
        chk(r, 8'h07);
        print_verdict();
    end
endmodule
